/* File: design/sts_stepper_seq.sv */
// Chosen here: register access over APB.
module sts_stepper_seq
   import sts_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq_a,
   output logic irq_b,
   input wire logic cha_pin_in,
   output logic cha_pin_out,
   output logic cha_pin_oe_n,
   input wire logic chb_pin_in,
   output logic chb_pin_out,
   output logic chb_pin_oe_n,
   output logic phase_a_out,
   output logic phase_b_out,
   output logic phase_a_inv_out,
   output logic phase_b_inv_out,
   output logic [PHASE_PINS-1:0] phase_oe_n
);

   typedef struct packed {
      logic [7:0] timer_mode;
      logic [7:0] timer_control;
      logic [7:0] timer_interrupt_enable;
      logic [7:0] compare_io_control;
      logic [15:0] up_counter;
      logic pend_clr;
      logic [7:0] phase_port_data;
      logic [7:0] phase_port_direction;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq_a;
      logic irq_b;
      logic [PHASE_PINS-1:0] phase;
      logic [PHASE_PINS-1:0] phase_oe_n;
   } sts_top_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release

   logic rs1;
   logic rs2;
   logic rst_n;

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rs1 <= 1'b0;
         rs2 <= 1'b0;
      end
      else
      begin
         rs1 <= 1'b1;
         rs2 <= rs1;
      end
   end

   assign rst_n = rs2;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   sts_top_state_t st;
   sts_top_state_t next_st;
   logic tick;
   logic upd;
   logic [15:0] word;
   logic mapped;
   logic [31:0] rd_val;
   logic wr_hit;
   logic [15:0] compare_a_period;
   logic [15:0] compare_b_point;
   logic flag_a;
   logic flag_b;
   logic clr_a;
   logic clr_b;
   logic cap_a;
   logic cap_b;

   assign word = paddr[ADDR_W-1:2];
   assign cap_a = st.compare_io_control[IO_A_CAP_BIT];
   assign cap_b = st.compare_io_control[IO_B_CAP_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Counter clock and compare channels

   sts_prescaler #(
      .W(PRESC_W)
   ) u_presc (
      .mclk(mclk),
      .rst_n(rst_n),
      .sel(st.timer_control[CTL_CKS_HI:CTL_CKS_LO]),
      .tick(tick)
   );

   // channel A compares against the period register
   sts_cmp_chan u_chan_a (
      .mclk(mclk),
      .rst_n(rst_n),
      .cnt(next_st.up_counter),
      .upd(upd),
      .gr_wr(wr_hit && word == IDX_CMPA),
      .wdata(pwdata[15:0]),
      .capture(cap_a),
      .action(st.compare_io_control[IO_A_ACT_HI:IO_A_ACT_LO]),
      .flag_clr(clr_a),
      .pin_in(cha_pin_in),
      .gr(compare_a_period),
      .flag(flag_a),
      .pin_out(cha_pin_out),
      .pin_oe_n(cha_pin_oe_n)
   );

   // channel B marks the point inside each step
   sts_cmp_chan u_chan_b (
      .mclk(mclk),
      .rst_n(rst_n),
      .cnt(next_st.up_counter),
      .upd(upd),
      .gr_wr(wr_hit && word == IDX_CMPB),
      .wdata(pwdata[15:0]),
      .capture(cap_b),
      .action(st.compare_io_control[IO_B_ACT_HI:IO_B_ACT_LO]),
      .flag_clr(clr_b),
      .pin_in(chb_pin_in),
      .gr(compare_b_point),
      .flag(flag_b),
      .pin_out(chb_pin_out),
      .pin_oe_n(chb_pin_oe_n)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read decode

   always_comb
   begin
      mapped = (paddr[1:0] == 2'h0);
      rd_val = 32'h0000_0000;
      unique case (word)
         IDX_MODE: rd_val[7:0] = st.timer_mode;
         IDX_CTRL: rd_val[7:0] = st.timer_control;
         IDX_IEN: rd_val[7:0] = st.timer_interrupt_enable;
         IDX_FLAGS:
         begin
            rd_val[FLG_A_BIT] = flag_a;
            rd_val[FLG_B_BIT] = flag_b;
         end
         IDX_IOCTL: rd_val[7:0] = st.compare_io_control;
         IDX_COUNT: rd_val[15:0] = st.up_counter;
         IDX_CMPA: rd_val[15:0] = compare_a_period;
         IDX_CMPB: rd_val[15:0] = compare_b_point;
         IDX_PDATA: rd_val[7:0] = st.phase_port_data;
         IDX_PDIR: rd_val[7:0] = st.phase_port_direction;
         default: mapped = 1'b0;
      endcase
      if (!mapped)
         rd_val = 32'h0000_0000;
   end

   // Writes land only at the completing access edge
   assign wr_hit = psel && penable && st.pready && pwrite && mapped;
   // Flags clear by writing zero; a one leaves them alone
   assign clr_a = wr_hit && word == IDX_FLAGS && !pwdata[FLG_A_BIT];
   assign clr_b = wr_hit && word == IDX_FLAGS && !pwdata[FLG_B_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      next_st = st;
      upd = 1'b0;
      // One wait-free answer: ready raised after the setup cycle
      next_st.pready = psel && !penable;
      next_st.pslverr = psel && !penable && !mapped;
      if (psel && !penable)
         next_st.prdata = rd_val;
      if (wr_hit)
      begin
         unique case (word)
            IDX_MODE: next_st.timer_mode = pwdata[7:0] & MODE_MASK;
            IDX_CTRL: next_st.timer_control = pwdata[7:0] & CTL_MASK;
            IDX_IEN: next_st.timer_interrupt_enable = pwdata[7:0] & IEN_MASK;
            IDX_IOCTL: next_st.compare_io_control = pwdata[7:0] & IO_MASK;
            IDX_PDATA: next_st.phase_port_data = pwdata[7:0];
            IDX_PDIR: next_st.phase_port_direction = pwdata[7:0];
            default: next_st.timer_mode = st.timer_mode;
         endcase
      end
      if (wr_hit && word == IDX_COUNT)
         next_st.up_counter = pwdata[15:0];
      else if (st.timer_mode[MODE_RUN_BIT] && tick)
      begin
         upd = 1'b1;
         // wrap to zero at the tick after match A
         if (st.timer_control[CTL_CLR_BIT] && st.pend_clr)
            next_st.up_counter = CNT_RST;
         else
            next_st.up_counter = st.up_counter + 16'h0001;
      end
      // Match latched so a reload of compare A cannot skip the clear
      if (wr_hit && word == IDX_COUNT)
         next_st.pend_clr = 1'b0;
      else if (upd)
         next_st.pend_clr = !cap_a && next_st.up_counter == compare_a_period;
      next_st.irq_a = flag_a && st.timer_interrupt_enable[IEN_A_BIT];
      next_st.irq_b = flag_b && st.timer_interrupt_enable[IEN_B_BIT];
      // direction bits turn the phase pins on
      for (int i = 0; i < PHASE_PINS; i++)
      begin
         next_st.phase_oe_n[i] = !st.phase_port_direction[i];
         next_st.phase[i] = st.phase_port_direction[i] && st.phase_port_data[i];
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st <= '0;
         st.timer_mode <= REG8_RST;
         st.timer_control <= REG8_RST;
         st.up_counter <= CNT_RST;
         st.phase_oe_n <= '1;
      end
      else
         st <= next_st;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign irq_a = st.irq_a;
   assign irq_b = st.irq_b;
   // bit 3 phase A down to bit 0 inverse B
   assign phase_a_out = st.phase[3];
   assign phase_b_out = st.phase[2];
   assign phase_a_inv_out = st.phase[1];
   assign phase_b_inv_out = st.phase[0];
   assign phase_oe_n = st.phase_oe_n;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_run_hold;
      @(posedge mclk) disable iff (!rst_n)
      (!st.timer_mode[MODE_RUN_BIT] && !(wr_hit && word == IDX_COUNT))
         |=> $stable(st.up_counter);
   endproperty
   a_run_hold: assert property (p_run_hold) else $error("counter moved while stopped");

   property p_clear_a;
      @(posedge mclk) disable iff (!rst_n)
      (tick && st.timer_mode[MODE_RUN_BIT] && st.timer_control[CTL_CLR_BIT] && !cap_a
         && st.up_counter == compare_a_period && !(wr_hit && word == IDX_COUNT))
         |=> st.up_counter == CNT_RST;
   endproperty
   a_clear_a: assert property (p_clear_a) else $error("counter not cleared on match A");

   property p_cnt_inc;
      @(posedge mclk) disable iff (!rst_n)
      (tick && st.timer_mode[MODE_RUN_BIT] && !st.timer_control[CTL_CLR_BIT]
         && !(wr_hit && word == IDX_COUNT))
         |=> st.up_counter == $past(st.up_counter) + 16'h0001;
   endproperty
   a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not advance");

   property p_match_a;
      @(posedge mclk) disable iff (!rst_n)
      (upd && !cap_a && next_st.up_counter == compare_a_period) |=> flag_a;
   endproperty
   a_match_a: assert property (p_match_a) else $error("match A event missing");

   property p_match_b;
      @(posedge mclk) disable iff (!rst_n)
      (upd && !cap_b && next_st.up_counter == compare_b_point) |=> flag_b;
   endproperty
   a_match_b: assert property (p_match_b) else $error("match B event missing");

   property p_irq_gate;
      @(posedge mclk) disable iff (!rst_n)
      (!st.timer_interrupt_enable[IEN_A_BIT] ##1 !st.timer_interrupt_enable[IEN_A_BIT])
         |-> !irq_a;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("masked request forwarded");

   property p_irq_b;
      @(posedge mclk) disable iff (!rst_n)
      (flag_b && st.timer_interrupt_enable[IEN_B_BIT]) |=> irq_b;
   endproperty
   a_irq_b: assert property (p_irq_b) else $error("enabled request B not raised");

   property p_phase_out;
      @(posedge mclk) disable iff (!rst_n)
      (st.phase_port_direction[3:0] == 4'hf) |=>
         phase_oe_n == 4'h0 &&
         {phase_a_out, phase_b_out, phase_a_inv_out, phase_b_inv_out}
            == $past(st.phase_port_data[3:0]);
   endproperty
   a_phase_out: assert property (p_phase_out) else $error("phase pins not following data");

   property p_bus_answer;
      @(posedge mclk) disable iff (!rst_n)
      (psel && !penable) |=> pready ##1 !pready;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

endmodule : sts_stepper_seq

/* File: design/sts_pkg.sv */
package sts_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam int ADDR_W = 18;
   localparam logic [15:0] IDX_MODE = 16'hff80;
   localparam logic [15:0] IDX_CTRL = 16'hff81;
   localparam logic [15:0] IDX_IEN = 16'hff82;
   localparam logic [15:0] IDX_FLAGS = 16'hff83;
   localparam logic [15:0] IDX_IOCTL = 16'hff84;
   localparam logic [15:0] IDX_COUNT = 16'hff86;
   localparam logic [15:0] IDX_CMPA = 16'hff88;
   localparam logic [15:0] IDX_CMPB = 16'hff8a;
   localparam logic [15:0] IDX_PDATA = 16'hffdb;
   localparam logic [15:0] IDX_PDIR = 16'hffeb;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int MODE_RUN_BIT = 7;
   localparam int CTL_CLR_BIT = 7;
   localparam int CTL_CKS_HI = 6;
   localparam int CTL_CKS_LO = 4;
   localparam int IEN_A_BIT = 0;
   localparam int IEN_B_BIT = 1;
   localparam int FLG_A_BIT = 0;
   localparam int FLG_B_BIT = 1;
   localparam int IO_B_CAP_BIT = 6;
   localparam int IO_B_ACT_HI = 5;
   localparam int IO_B_ACT_LO = 4;
   localparam int IO_A_CAP_BIT = 2;
   localparam int IO_A_ACT_HI = 1;
   localparam int IO_A_ACT_LO = 0;
   localparam int PHASE_PINS = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Writable bits and reset values
   localparam logic [7:0] MODE_MASK = 8'h80;
   localparam logic [7:0] CTL_MASK = 8'hf0;
   localparam logic [7:0] IEN_MASK = 8'h03;
   localparam logic [7:0] IO_MASK = 8'h77;
   localparam logic [7:0] REG8_RST = 8'h00;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] GR_RST = 16'hffff;

   ////////////////////////////////////////////////////////////////////////////
   // Clock select codes and pin actions
   localparam int PRESC_W = 3;
   localparam logic [2:0] CKS_DIV1 = 3'h0;
   localparam logic [2:0] CKS_DIV2 = 3'h1;
   localparam logic [2:0] CKS_DIV4 = 3'h2;
   localparam logic [2:0] CKS_DIV8 = 3'h3;
   localparam int DIV8_GAP = 7;
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_LOW = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;

endpackage : sts_pkg

/* File: design/sts_prescaler.sv */
module sts_prescaler
   import sts_pkg::*;
#(
   parameter int W = PRESC_W
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [2:0] sel,
   output logic tick
);

   typedef struct packed {
      logic [W-1:0] div;
      logic tick;
   } sts_presc_state_t;

   sts_presc_state_t st;
   sts_presc_state_t next_st;

   always_comb
   begin
      next_st = st;
      next_st.div = st.div + 1'b1;
      unique case (sel)
         CKS_DIV1: next_st.tick = 1'b1;
         CKS_DIV2: next_st.tick = st.div[0];
         CKS_DIV4: next_st.tick = &st.div[1:0];
         CKS_DIV8: next_st.tick = &st.div[2:0];
         // No external clock here: other codes hold the counter
         default: next_st.tick = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end

   assign tick = st.tick;

   property p_div8;
      @(posedge mclk) disable iff (!rst_n)
      (sel == CKS_DIV8 && $stable(sel) && st.tick) |=> (!st.tick)[*7] ##1 st.tick;
   endproperty
   a_div8: assert property (p_div8) else $error("divide by eight tick spacing wrong");

endmodule : sts_prescaler

/* File: design/sts_cmp_chan.sv */
module sts_cmp_chan
   import sts_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [15:0] cnt,
   input wire logic upd,
   input wire logic gr_wr,
   input wire logic [15:0] wdata,
   input wire logic capture,
   input wire logic [1:0] action,
   input wire logic flag_clr,
   input wire logic pin_in,
   output logic [15:0] gr,
   output logic flag,
   output logic pin_out,
   output logic pin_oe_n
);

   typedef struct packed {
      logic [15:0] gr;
      logic flag;
      logic s1;
      logic s2;
      logic prev;
      logic pin_out;
      logic pin_oe_n;
   } sts_chan_state_t;

   sts_chan_state_t st;
   sts_chan_state_t next_st;
   logic match;
   logic cap_ev;

   always_comb
   begin
      next_st = st;
      next_st.s1 = pin_in;
      next_st.s2 = st.s1;
      next_st.prev = st.s2;
      // equality seen as the counter arrives
      match = upd && !capture && (cnt == st.gr);
      cap_ev = capture && st.s2 && !st.prev;
      if (gr_wr)
         next_st.gr = wdata;
      else if (cap_ev)
         next_st.gr = cnt;
      // Set beats a clear in the same cycle
      if (match || cap_ev)
         next_st.flag = 1'b1;
      else if (flag_clr)
         next_st.flag = 1'b0;
      // pin released in capture mode or when no action is chosen
      next_st.pin_oe_n = capture || (action == ACT_NONE);
      if (match)
      begin
         unique case (action)
            ACT_NONE: next_st.pin_out = st.pin_out;
            ACT_LOW: next_st.pin_out = 1'b0;
            ACT_HIGH: next_st.pin_out = 1'b1;
            ACT_TOGGLE: next_st.pin_out = !st.pin_out;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st <= '0;
         st.gr <= GR_RST;
         st.pin_oe_n <= 1'b1;
      end
      else
         st <= next_st;
   end

   assign gr = st.gr;
   assign flag = st.flag;
   assign pin_out = st.pin_out;
   assign pin_oe_n = st.pin_oe_n;

   property p_flag_set;
      @(posedge mclk) disable iff (!rst_n)
      (upd && !capture && cnt == st.gr) |=> st.flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("match did not raise flag");

   property p_capture;
      @(posedge mclk) disable iff (!rst_n)
      (capture && !gr_wr && st.s2 && !st.prev) |=> st.gr == $past(cnt) && st.flag;
   endproperty
   a_capture: assert property (p_capture) else $error("capture value lost");

   property p_pin_idle;
      @(posedge mclk) disable iff (!rst_n)
      (action == ACT_NONE) [*2] |-> st.pin_oe_n && $stable(st.pin_out);
   endproperty
   a_pin_idle: assert property (p_pin_idle) else $error("pin driven with action none");

endmodule : sts_cmp_chan

/* File: tb/sts_motor_drv.sv */
module sts_motor_drv (
   input wire logic pa,
   input wire logic pb,
   input wire logic pai,
   input wire logic pbi,
   input wire logic [3:0] oe_n,
   output logic [3:0] pat,
   output logic fault
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////
   // A, B, inverse A, inverse B
   // Driver inputs pulled down when not driven
   assign pat = {pa, pb, pai, pbi} & ~oe_n;

   ////////////////////////////////////////////////////////////////////////////
   // opposite windings never on together
   // Sticky, so a one-cycle overlap is not lost
   initial fault = 1'b0;
   always @(pat)
   begin
      if ((pat[3] && pat[1]) || (pat[2] && pat[0]))
      begin
         fault = 1'b1;
      end
   end
endmodule : sts_motor_drv

/* File: tb/sts_stepper_seq_tb.sv */
module sts_stepper_seq_tb
   import sts_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, arst_n, psel, penable, pwrite, cha_in, chb_in, er;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, irq_a, irq_b, cha_out, cha_oe_n, chb_out, chb_oe_n;
   logic pa, pb, pai, pbi, fault, ia_d, ib_d;
   logic [3:0] poe_n, pat;
   logic [7:0] p;
   int error_cnt, checks, cyc, ta, tb, t1, t2, t3;
   logic [15:0] ridx [10] = '{IDX_MODE, IDX_CTRL, IDX_IEN, IDX_FLAGS, IDX_IOCTL,
      IDX_COUNT, IDX_CMPA, IDX_CMPB, IDX_PDATA, IDX_PDIR};
   logic [31:0] rrst [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
      32'hffff, 32'hffff, 32'h0, 32'h0};
   logic [15:0] widx [4] = '{IDX_CTRL, IDX_IOCTL, IDX_IEN, IDX_MODE};
   logic [31:0] wmsk [4] = '{32'hf0, 32'h77, 32'h03, 32'h80};
   logic [7:0] pt [8] = '{8'h08, 8'h0c, 8'h04, 8'h06, 8'h02, 8'h03, 8'h01, 8'h09};

   ////////////////////////////////////////////////////////////////////////////
   sts_stepper_seq uut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_a(irq_a), .irq_b(irq_b), .cha_pin_in(cha_in),
      .cha_pin_out(cha_out), .cha_pin_oe_n(cha_oe_n), .chb_pin_in(chb_in),
      .chb_pin_out(chb_out), .chb_pin_oe_n(chb_oe_n), .phase_a_out(pa), .phase_b_out(pb),
      .phase_a_inv_out(pai), .phase_b_inv_out(pbi), .phase_oe_n(poe_n));
   sts_motor_drv drv (.pa(pa), .pb(pb), .pai(pai), .pbi(pbi), .oe_n(poe_n), .pat(pat),
      .fault(fault));

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // Interrupt rise times, in clock cycles
   always @(posedge mclk) cyc <= cyc + 1;
   always @(negedge mclk)
   begin
      if (irq_a === 1'b1 && ia_d !== 1'b1) ta = cyc;
      if (irq_b === 1'b1 && ib_d !== 1'b1) tb = cyc;
      ia_d <= irq_a;
      ib_d <= irq_b;
   end

   ////////////////////////////////////////////////////////////////////////////
   task report_and_stop;
      $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
      begin
         $display("All checks passed");
      end
      else
      begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop

   task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: %s got %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk

   // Holds the request until pready is seen high
   task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      // Answer taken at the rising edge that completes the access
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      chk(pready, 1, "no pready");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [15:0] idx, input logic [31:0] d);
      apb(1'b1, {idx, 2'b00}, d);
   endtask : wr

   task rdc(input logic [15:0] idx, input logic [31:0] exp, input string msg);
      apb(1'b0, {idx, 2'b00}, 32'h0);
      chk(rd, exp, msg);
   endtask : rdc

   task wait_ev(input bit on_b, output int t);
      int n;
      int old;
      old = on_b ? tb : ta;
      n = 0;
      while ((on_b ? tb : ta) == old && n < 4000)
      begin
         @(negedge mclk);
         n++;
      end
      t = on_b ? tb : ta;
      chk(32'(n < 4000), 1, "event timeout");
   endtask : wait_ev

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      report_and_stop();
   end

   initial
   begin
      {psel, penable, pwrite, cha_in, chb_in, arst_n, ia_d, ib_d} = '0;
      paddr = '0;
      pwdata = '0;
      {error_cnt, checks, cyc, ta, tb} = '0;
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      chk(cha_oe_n, 1, "pin idle");
      chk(poe_n, 4'hf, "phase oe");
      for (int i = 0; i < 10; i++) rdc(ridx[i], rrst[i], "reset");
      apb(1'b0, {16'hff85, 2'b00}, 32'h0);
      chk(er, 1, "unmapped err");
      chk(rd, 0, "unmapped data");
      apb(1'b1, {IDX_MODE, 2'b01}, 32'h80);
      chk(er, 1, "misaligned err");
      // Control first: code 111 keeps the counter still
      for (int i = 0; i < 4; i++) wr(widx[i], 32'hff);
      for (int i = 0; i < 4; i++) rdc(widx[i], wmsk[i], "mask");
      rdc(IDX_COUNT, 0, "stopped code");
      wr(IDX_COUNT, 32'h1_1234);
      rdc(IDX_COUNT, 32'h1234, "count rw");
      for (int i = 0; i < 4; i++) wr(widx[i], 32'h0);
      wr(IDX_CTRL, 32'h30);
      wr(IDX_COUNT, 32'h5);
      repeat (40) @(negedge mclk);
      rdc(IDX_COUNT, 32'h5, "run off");
      wr(IDX_CMPA, 32'h8);
      wr(IDX_MODE, 32'h80);
      repeat (120) @(negedge mclk);
      apb(1'b0, {IDX_COUNT, 2'b00}, 32'h0);
      chk(32'(rd[15:0] > 16'h8), 1, "no clear");
      rdc(IDX_FLAGS, 32'h1, "flag a");
      chk(irq_a, 0, "irq masked");
      // Main run: period 20, gap 5, clear on A
      wr(IDX_MODE, 32'h0);
      wr(IDX_COUNT, 32'h0);
      wr(IDX_CMPA, 32'd20);
      wr(IDX_CMPB, 32'd5);
      wr(IDX_IOCTL, 32'h02);
      wr(IDX_IEN, 32'h03);
      wr(IDX_FLAGS, 32'h0);
      wr(IDX_CTRL, 32'hb0);
      wr(IDX_MODE, 32'h80);
      wait_ev(1'b0, t1);
      wr(IDX_FLAGS, 32'h0);
      wait_ev(1'b1, t2);
      wr(IDX_FLAGS, 32'h0);
      wait_ev(1'b0, t3);
      chk(32'(t2 - t1), 32'((5 + 1) * 8), "b after a");
      chk(32'(t3 - t1), 32'((20 + 1) * 8), "period a");
      chk(cha_out, 1, "pin high");
      chk(cha_oe_n, 0, "pin driven");
      chk(chb_oe_n, 1, "pin b idle");
      // Ramp step: reload lands before the clear tick
      wr(IDX_FLAGS, 32'h0);
      wait_ev(1'b0, t1);
      wr(IDX_CMPA, 32'd12);
      wr(IDX_FLAGS, 32'h0);
      wait_ev(1'b0, t2);
      chk(32'(t2 - t1), 32'((12 + 1) * 8), "reloaded period");
      wr(IDX_IOCTL, 32'h22);
      wr(IDX_IEN, 32'h01);
      wr(IDX_FLAGS, 32'h0);
      wait_ev(1'b0, t1);
      repeat (60) @(negedge mclk);
      chk(irq_b, 0, "irq b masked");
      chk(irq_a, 1, "irq a on");
      chk(chb_out, 1, "pin b high");
      chk(chb_oe_n, 0, "pin b driven");
      rdc(IDX_FLAGS, 32'h3, "both flags");
      wr(IDX_IOCTL, 32'h44);
      wr(IDX_FLAGS, 32'h0);
      repeat (200) @(negedge mclk);
      rdc(IDX_FLAGS, 32'h0, "capture no match");
      cha_in <= 1'b1;
      chb_in <= 1'b1;
      repeat (6) @(negedge mclk);
      rdc(IDX_FLAGS, 32'h3, "capture edge");
      // Phase port: forward, stop, reverse, stop
      wr(IDX_PDATA, 32'h08);
      repeat (2) @(negedge mclk);
      chk(pat, 0, "not output");
      wr(IDX_PDIR, 32'h0f);
      repeat (2) @(negedge mclk);
      chk(poe_n, 0, "outputs on");
      chk(pat, 4'h8, "first pattern");
      for (int i = 0; i < 16; i++)
      begin
         p = (i < 8) ? pt[i] : pt[15 - i];
         wr(IDX_PDATA, 32'(p));
         repeat (2) @(negedge mclk);
         chk(pat, 32'(p), "pattern");
         if (i == 7)
         begin
            repeat (20) @(negedge mclk);
            chk(pat, 4'h9, "stop fwd");
         end
      end
      repeat (20) @(negedge mclk);
      chk(pat, 4'h8, "hold");
      chk(fault, 0, "overlap");
      report_and_stop();
   end
endmodule : sts_stepper_seq_tb
